/* hdl/exec_pkg.sv */
// Shared opcodes, status bit positions, reset values and cycle counts.
// Contract
// RQ1: Register add, with or without incoming carry, writes the sum, updates Z C N V H and takes one cycle.
// RQ2: Word add or subtract of a six-bit constant on a register pair updates Z C N V S and takes two cycles.
// RQ3: Subtract of a register or constant writes the difference, updates Z C N V H and takes one cycle.
// RQ4: Subtract with borrow of a register or constant writes the result, updates Z C N V H in one cycle.
// RQ5: AND, OR and XOR with a register or constant write the result, update only Z N V, in one cycle.
// RQ6: Set-mask-bits ORs a constant into the register, updates only Z N V, in one cycle.
// RQ7: Zero-or-minus check ANDs a register with itself, keeps its value, updates Z N V in one cycle.
// RQ8: Pointer jump loads the program counter from the pointer pair, keeps flags, takes two cycles.
// RQ9: Pointer call pushes the return point, loads the pointer pair into the counter, takes three cycles.
// RQ10: Equal-then-skip skips the next instruction when both registers match, keeping all flags.
// RQ11: Compares compute a difference without storing it and update Z N V C H in one cycle.
// RQ12: Register-bit skips test one bit of a register and skip when it has the wanted level.
// RQ13: I/O-bit skips test one bit of an I/O value and skip when it has the wanted level.
// RQ14: Status-bit branches jump to counter plus offset plus one when taken, one cycle untaken, two taken.
// RQ15: Branch-no-carry jumps relative only when carry is clear, keeps flags, one or two cycles.
// RQ16: A taken skip takes two cycles over a one-word and three over a two-word instruction, else one.
package exec_pkg;

  typedef enum logic [4:0] {
    OP_ADD         = 5'h00,
    OP_ADD_CARRY   = 5'h01,
    OP_WORD_SUM    = 5'h02,
    OP_SUB         = 5'h03,
    OP_IMM_DIFF    = 5'h04,
    OP_DIFF_BRW    = 5'h05,
    OP_IMM_DIFF_BRW = 5'h06,
    OP_WORD_DIFF   = 5'h07,
    OP_AND         = 5'h08,
    OP_MASK_IMM    = 5'h09,
    OP_OR          = 5'h0a,
    OP_MERGE_IMM   = 5'h0b,
    OP_EXCL_MERGE  = 5'h0c,
    OP_SET_MASK    = 5'h0d,
    OP_ZERO_MINUS  = 5'h0e,
    OP_PTR_JUMP    = 5'h0f,
    OP_PTR_CALL    = 5'h10,
    OP_EQUAL_SKIP  = 5'h11,
    OP_REG_CMP     = 5'h12,
    OP_CMP_BRW     = 5'h13,
    OP_IMM_CMP     = 5'h14,
    OP_SKIP_REG_LO = 5'h15,
    OP_SKIP_REG_HI = 5'h16,
    OP_SKIP_IO_LO  = 5'h17,
    OP_SKIP_IO_HI  = 5'h18,
    OP_BR_STAT_HI  = 5'h19,
    OP_BR_STAT_LO  = 5'h1a,
    OP_BR_NO_CARRY = 5'h1b
  } op_e;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_OR  = 3'h3,
    ALU_XOR = 3'h4
  } alu_e;

  // Status register bit positions.
  localparam int unsigned SR_C = 0;
  localparam int unsigned SR_Z = 1;
  localparam int unsigned SR_N = 2;
  localparam int unsigned SR_V = 3;
  localparam int unsigned SR_S = 4;
  localparam int unsigned SR_H = 5;

  localparam logic [7:0]  STATUS_REGISTER_RST   = 8'h00;
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam logic [7:0]  RF_RST     = 8'h00;
  localparam logic [4:0]  PTR_LO_IDX = 5'h1e;
  localparam logic [4:0]  PTR_HI_IDX = 5'h1f;

  // Extra stall cycles after the accepting edge (total cycles minus one).
  localparam logic [1:0] HOLD_ONE   = 2'h0;
  localparam logic [1:0] HOLD_TWO   = 2'h1;
  localparam logic [1:0] HOLD_THREE = 2'h2;

endpackage : exec_pkg

/* hdl/alu8.sv */
// Eight-bit arithmetic and logic unit with flag generation.
`timescale 1ns/1ps
module alu8 (
  // Operands
  input  wire logic [7:0]   a,
  input  wire logic [7:0]   b,
  input  wire logic         cin,
  input  wire exec_pkg::alu_e kind,
  // Result and flags
  output logic [7:0]        res,
  output logic              c_out,
  output logic              z_out,
  output logic              n_out,
  output logic              v_out,
  output logic              h_out
);
  import exec_pkg::*;

  logic [8:0] wide;

  always_comb begin
    wide  = 9'h000;
    c_out = 1'b0;
    v_out = 1'b0;
    h_out = 1'b0;
    case (kind)
      ALU_ADD: begin
        wide  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        c_out = wide[8];
        v_out = (a[7] & b[7] & ~wide[7]) | (~a[7] & ~b[7] & wide[7]);
        h_out = (a[3] & b[3]) | (b[3] & ~wide[3]) | (~wide[3] & a[3]);
      end
      ALU_SUB: begin
        wide  = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        c_out = wide[8];
        v_out = (a[7] & ~b[7] & ~wide[7]) | (~a[7] & b[7] & wide[7]);
        h_out = (~a[3] & b[3]) | (b[3] & wide[3]) | (wide[3] & ~a[3]);
      end
      // Logic results always clear overflow.
      ALU_AND: wide = {1'b0, a & b};
      ALU_OR:  wide = {1'b0, a | b};
      ALU_XOR: wide = {1'b0, a ^ b};
      default: wide = 9'h000;
    endcase
    res   = wide[7:0];
    z_out = (wide[7:0] == 8'h00);
    n_out = wide[7];
  end

endmodule : alu8

/* hdl/exec_core.sv */
// Execution unit for arithmetic, logic, compare, skip and branch operations.
`timescale 1ns/1ps
module exec_core #(
  parameter int unsigned PC_W = 16
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // Decoded instruction
  input  wire logic               instr_valid,
  output logic                    instr_ready,
  input  wire exec_pkg::op_e      instr_op,
  input  wire logic [4:0]         rd_idx,
  input  wire logic [4:0]         rr_idx,
  input  wire logic [7:0]         imm_k,
  input  wire logic [2:0]         bit_sel,
  input  wire logic [6:0]         br_offset,
  input  wire logic               next_two_word,
  input  wire logic [7:0]         io_value,
  // Register and status preload
  input  wire logic               rf_load_en,
  input  wire logic [4:0]         rf_load_idx,
  input  wire logic [7:0]         rf_load_data,
  input  wire logic               status_register_load_en,
  input  wire logic [7:0]         status_register_load_data,
  input  wire logic [4:0]         rf_peek_idx,
  output logic [7:0]              rf_peek_data,
  // Core state
  output logic [PC_W-1:0]         pc_out,
  output logic [7:0]              status_register_out,
  output logic                    stack_push,
  output logic [PC_W-1:0]         stack_data
);
  import exec_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } state_e;

  state_e          state_r;
  logic [1:0]      hold_r;
  logic [7:0]      rf_r [32];
  logic [PC_W-1:0] pc_r;
  logic [7:0]      status_register_r;
  logic            push_r;
  logic [PC_W-1:0] push_data_r;
  logic [7:0]      peek_r;

  logic            accept;
  logic [7:0]      opa;
  logic [7:0]      opb;
  logic            alu_cin;
  alu_e            alu_kind;
  logic [7:0]      alu_res;
  logic            alu_c;
  logic            alu_z;
  logic            alu_n;
  logic            alu_v;
  logic            alu_h;
  logic [4:0]      pair_lo;
  logic [15:0]     pair_val;
  logic [15:0]     word_res;
  logic [15:0]     ptr_val;
  logic [PC_W-1:0] off_ext;
  logic            rf_we;
  logic            word_we;
  logic [7:0]      status_register_nxt;
  logic [PC_W-1:0] pc_nxt;
  logic [1:0]      hold_nxt;
  logic            skip;
  logic            take;

  function automatic logic is_imm(input op_e op);
    return op inside {OP_IMM_DIFF, OP_IMM_DIFF_BRW, OP_MASK_IMM,
                      OP_MERGE_IMM, OP_SET_MASK, OP_IMM_CMP};
  endfunction

  assign accept       = instr_valid && instr_ready;
  assign instr_ready  = (state_r == ST_IDLE);
  assign pc_out       = pc_r;
  assign status_register_out     = status_register_r;
  assign stack_push   = push_r;
  assign stack_data   = push_data_r;
  assign rf_peek_data = peek_r;

  assign opa      = rf_r[rd_idx];
  assign pair_lo  = {rd_idx[4:1], 1'b0};
  assign pair_val = {rf_r[pair_lo | 5'h01], rf_r[pair_lo]};
  assign ptr_val  = {rf_r[PTR_HI_IDX], rf_r[PTR_LO_IDX]};
  assign off_ext  = PC_W'({{(PC_W-7){br_offset[6]}}, br_offset});

  always_comb begin
    opb      = is_imm(instr_op) ? imm_k : rf_r[rr_idx];
    alu_cin  = 1'b0;
    alu_kind = ALU_SUB;
    case (instr_op)
      OP_ADD:        alu_kind = ALU_ADD;
      OP_ADD_CARRY: begin
        alu_kind = ALU_ADD;
        alu_cin  = status_register_r[SR_C];
      end
      OP_DIFF_BRW, OP_IMM_DIFF_BRW, OP_CMP_BRW: alu_cin = status_register_r[SR_C];
      OP_AND, OP_MASK_IMM: alu_kind = ALU_AND;
      OP_OR, OP_MERGE_IMM, OP_SET_MASK: alu_kind = ALU_OR;
      OP_EXCL_MERGE: alu_kind = ALU_XOR;
      OP_ZERO_MINUS: begin
        alu_kind = ALU_AND;
        opb      = opa;
      end
      default:       alu_kind = ALU_SUB;
    endcase
  end

  alu8 u_alu (
    .a     (opa),
    .b     (opb),
    .cin   (alu_cin),
    .kind  (alu_kind),
    .res   (alu_res),
    .c_out (alu_c),
    .z_out (alu_z),
    .n_out (alu_n),
    .v_out (alu_v),
    .h_out (alu_h)
  );

  always_comb begin
    word_res = (instr_op == OP_WORD_DIFF) ? pair_val - {10'h000, imm_k[5:0]}
                                          : pair_val + {10'h000, imm_k[5:0]};
    status_register_nxt = status_register_r;
    rf_we    = 1'b0;
    word_we  = 1'b0;
    hold_nxt = HOLD_ONE;
    pc_nxt   = pc_r + PC_W'(1);
    skip     = 1'b0;
    take     = 1'b0;
    case (instr_op)
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_IMM_DIFF, OP_DIFF_BRW,
      OP_IMM_DIFF_BRW, OP_REG_CMP, OP_CMP_BRW, OP_IMM_CMP: begin
        // Compares share the subtract path but never write back.
        rf_we = !(instr_op inside {OP_REG_CMP, OP_CMP_BRW, OP_IMM_CMP});
        status_register_nxt[SR_Z] = alu_z; // [RQ1] [RQ3] [RQ4] [RQ11]
        status_register_nxt[SR_C] = alu_c;
        status_register_nxt[SR_N] = alu_n;
        status_register_nxt[SR_V] = alu_v;
        status_register_nxt[SR_H] = alu_h;
      end
      OP_WORD_SUM, OP_WORD_DIFF: begin
        word_we  = 1'b1;
        hold_nxt = HOLD_TWO; // [RQ2]
        status_register_nxt[SR_Z] = (word_res == 16'h0000);
        status_register_nxt[SR_N] = word_res[15];
        if (instr_op == OP_WORD_SUM) begin
          status_register_nxt[SR_V] = ~pair_val[15] & word_res[15];
          status_register_nxt[SR_C] = ~word_res[15] & pair_val[15];
        end else begin
          status_register_nxt[SR_V] = pair_val[15] & ~word_res[15];
          status_register_nxt[SR_C] = word_res[15] & ~pair_val[15];
        end
        status_register_nxt[SR_S] = word_res[15] ^ status_register_nxt[SR_V];
      end
      OP_AND, OP_MASK_IMM, OP_OR, OP_MERGE_IMM, OP_EXCL_MERGE,
      OP_SET_MASK, OP_ZERO_MINUS: begin
        // The check leaves its register alone.
        rf_we = (instr_op != OP_ZERO_MINUS); // [RQ7]
        status_register_nxt[SR_Z] = alu_z; // [RQ5] [RQ6] [RQ7]
        status_register_nxt[SR_N] = alu_n;
        status_register_nxt[SR_V] = 1'b0;
      end
      OP_PTR_JUMP: begin
        pc_nxt   = PC_W'(ptr_val); // [RQ8]
        hold_nxt = HOLD_TWO;
      end
      OP_PTR_CALL: begin
        pc_nxt   = PC_W'(ptr_val); // [RQ9]
        hold_nxt = HOLD_THREE;
      end
      OP_EQUAL_SKIP:  skip = (opa == rf_r[rr_idx]); // [RQ10]
      OP_SKIP_REG_LO: skip = !rf_r[rr_idx][bit_sel]; // [RQ12]
      OP_SKIP_REG_HI: skip = rf_r[rr_idx][bit_sel];
      OP_SKIP_IO_LO:  skip = !io_value[bit_sel]; // [RQ13]
      OP_SKIP_IO_HI:  skip = io_value[bit_sel];
      OP_BR_STAT_HI:  take = status_register_r[bit_sel]; // [RQ14]
      OP_BR_STAT_LO:  take = !status_register_r[bit_sel];
      OP_BR_NO_CARRY: take = !status_register_r[SR_C]; // [RQ15]
      default:        take = 1'b0;
    endcase
    if (skip) begin
      // The decoder tells us how long the skipped instruction is.
      pc_nxt   = pc_r + (next_two_word ? PC_W'(3) : PC_W'(2)); // [RQ16]
      hold_nxt = next_two_word ? HOLD_THREE : HOLD_TWO;
    end
    if (take) begin
      pc_nxt   = pc_r + off_ext + PC_W'(1); // [RQ14] [RQ15]
      hold_nxt = HOLD_TWO;
    end
  end

  // Sequencer: all results commit on the accepting edge, then we stall.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      hold_r  <= HOLD_ONE;
    end else begin
      case (state_r)
        ST_IDLE: if (accept && hold_nxt != HOLD_ONE) begin
          state_r <= ST_HOLD;
          hold_r  <= hold_nxt;
        end
        ST_HOLD: begin
          hold_r <= hold_r - 2'h1;
          if (hold_r == HOLD_TWO)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r   <= PC_W'(PC_RST);
      status_register_r <= STATUS_REGISTER_RST;
    end else begin
      if (accept)
        pc_r <= pc_nxt;
      if (accept)
        status_register_r <= status_register_nxt;
      else if (status_register_load_en)
        status_register_r <= status_register_load_data;
    end
  end

  // The return point is handed to the external stack as one pulse.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      push_r      <= 1'b0;
      push_data_r <= '0;
    end else begin
      push_r <= accept && (instr_op == OP_PTR_CALL); // [RQ9]
      if (accept && (instr_op == OP_PTR_CALL))
        push_data_r <= pc_r + PC_W'(1);
    end
  end

  // Execution writes win over the preload port in the same cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++)
        rf_r[i] <= RF_RST;
      peek_r <= RF_RST;
    end else begin
      peek_r <= rf_r[rf_peek_idx];
      if (rf_load_en)
        rf_r[rf_load_idx] <= rf_load_data;
      if (accept && rf_we)
        rf_r[rd_idx] <= alu_res; // [RQ1] [RQ3] [RQ4] [RQ5] [RQ6]
      if (accept && word_we) begin
        rf_r[pair_lo]         <= word_res[7:0]; // [RQ2]
        rf_r[pair_lo | 5'h01] <= word_res[15:8];
      end
    end
  end

  AST_ADD_ONE_CYCLE: assert property (@(posedge sys_clk) // [RQ1]
    disable iff (!rst_n)
    accept && instr_op inside {OP_ADD, OP_ADD_CARRY}
    |=> instr_ready && status_register_r[SR_C] == $past(alu_c))
    else $error("add did not finish in one cycle with its carry");

  AST_WORD_TWO_CYCLES: assert property (@(posedge sys_clk) // [RQ2]
    disable iff (!rst_n)
    accept && instr_op inside {OP_WORD_SUM, OP_WORD_DIFF}
    |=> !instr_ready ##1 instr_ready)
    else $error("word operation did not take two cycles");

  AST_SUB_ZERO: assert property (@(posedge sys_clk) // [RQ3]
    disable iff (!rst_n)
    accept && instr_op inside {OP_SUB, OP_IMM_DIFF}
    |=> instr_ready && status_register_r[SR_Z] == ($past(alu_res) == 8'h00))
    else $error("subtract zero flag or timing wrong");

  AST_BORROW_KEEPS_S: assert property (@(posedge sys_clk) // [RQ4]
    disable iff (!rst_n)
    accept && instr_op inside {OP_DIFF_BRW, OP_IMM_DIFF_BRW}
    |=> status_register_r[SR_S] == $past(status_register_r[SR_S]) && instr_ready)
    else $error("borrow subtract touched S or stalled");

  AST_LOGIC_FLAGS: assert property (@(posedge sys_clk) // [RQ5]
    disable iff (!rst_n)
    accept && instr_op inside {OP_AND, OP_OR, OP_EXCL_MERGE, OP_MASK_IMM}
    |=> !status_register_r[SR_V] && status_register_r[SR_C] == $past(status_register_r[SR_C]))
    else $error("logic operation flags wrong");

  AST_SET_MASK: assert property (@(posedge sys_clk) // [RQ6]
    disable iff (!rst_n)
    accept && instr_op == OP_SET_MASK
    |=> status_register_r[SR_H] == $past(status_register_r[SR_H])
        && status_register_r[SR_N] == $past(opa[7] | imm_k[7]))
    else $error("set mask bits flags wrong");

  AST_CHECK_NO_WRITE: assert property (@(posedge sys_clk) // [RQ7]
    disable iff (!rst_n)
    accept && instr_op == OP_ZERO_MINUS |-> !rf_we && alu_res == opa)
    else $error("zero or minus check altered its register");

  AST_PTR_JUMP: assert property (@(posedge sys_clk) // [RQ8]
    disable iff (!rst_n)
    accept && instr_op == OP_PTR_JUMP
    |=> pc_r == PC_W'($past(ptr_val)) && !instr_ready ##1 instr_ready)
    else $error("pointer jump target or timing wrong");

  AST_PTR_CALL: assert property (@(posedge sys_clk) // [RQ9]
    disable iff (!rst_n)
    accept && instr_op == OP_PTR_CALL
    |=> stack_push && stack_data == $past(pc_r) + PC_W'(1)
        ##0 !instr_ready[*2] ##1 instr_ready)
    else $error("pointer call push or timing wrong");

  AST_EQ_SKIP_FLAGS: assert property (@(posedge sys_clk) // [RQ10]
    disable iff (!rst_n)
    accept && instr_op == OP_EQUAL_SKIP |=> $stable(status_register_r))
    else $error("equal skip changed flags");

  AST_CMP_NO_WRITE: assert property (@(posedge sys_clk) // [RQ11]
    disable iff (!rst_n)
    accept && instr_op inside {OP_REG_CMP, OP_CMP_BRW, OP_IMM_CMP}
    |-> !rf_we ##1 instr_ready)
    else $error("compare wrote back or stalled");

  AST_REG_BIT_SKIP: assert property (@(posedge sys_clk) // [RQ12]
    disable iff (!rst_n)
    accept && instr_op == OP_SKIP_REG_HI && rf_r[rr_idx][bit_sel]
    && !next_two_word |=> pc_r == $past(pc_r) + PC_W'(2))
    else $error("register bit skip target wrong");

  AST_IO_BIT_SKIP: assert property (@(posedge sys_clk) // [RQ13]
    disable iff (!rst_n)
    accept && instr_op == OP_SKIP_IO_LO && io_value[bit_sel]
    |=> pc_r == $past(pc_r) + PC_W'(1) && instr_ready)
    else $error("untaken io skip not one cycle");

  AST_BRANCH_TAKEN: assert property (@(posedge sys_clk) // [RQ14]
    disable iff (!rst_n)
    accept && instr_op == OP_BR_STAT_HI && status_register_r[bit_sel]
    |=> pc_r == $past(pc_r) + $past(off_ext) + PC_W'(1)
        && !instr_ready ##1 instr_ready)
    else $error("taken status branch wrong");

  AST_NO_CARRY_UNTAKEN: assert property (@(posedge sys_clk) // [RQ15]
    disable iff (!rst_n)
    accept && instr_op == OP_BR_NO_CARRY && status_register_r[SR_C]
    |=> pc_r == $past(pc_r) + PC_W'(1) && instr_ready)
    else $error("branch on clear carry taken with carry set");

  AST_LONG_SKIP: assert property (@(posedge sys_clk) // [RQ16]
    disable iff (!rst_n)
    accept && skip && next_two_word
    |=> pc_r == $past(pc_r) + PC_W'(3) ##0 !instr_ready[*2] ##1 instr_ready)
    else $error("skip over two-word instruction wrong");

endmodule : exec_core

/* verification/test_alu_branch_instruction_exec.sv */
// Self-checking bench for the execution core with a queued reference model.
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  num_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module test_alu_branch_instruction_exec;
  import exec_pkg::*;
  typedef struct {
    logic [15:0] pc;
    logic [7:0]  sr;
    logic [7:0]  rv;
    int          cyc;
    bit          call;
    logic [15:0] stk;
  } note_s;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        instr_valid = 1'b0;
  logic        instr_ready;
  op_e         instr_op = OP_ADD;
  logic [4:0]  rd_idx = 5'h00, rr_idx = 5'h00, rf_load_idx = 5'h00;
  logic [4:0]  rf_peek_idx = 5'h00;
  logic [7:0]  imm_k = 8'h00, io_value = 8'h00, rf_load_data = 8'h00;
  logic [7:0]  status_register_load_data = 8'h00, rf_peek_data, status_register_out;
  logic [2:0]  bit_sel = 3'h0;
  logic [6:0]  br_offset = 7'h00;
  logic        next_two_word = 1'b0, rf_load_en = 1'b0, status_register_load_en = 1'b0;
  logic        stack_push;
  logic [15:0] pc_out, stack_data;
  int          num_errors = 0, comparisons = 0, cnt = 0, pushes = 0;
  bit          active = 1'b0, pk_pend = 1'b0;
  logic [7:0]  pk_val, rf [32], sr;
  logic [15:0] pc;
  logic [31:0] seed = 32'hcdc22164;
  note_s       notes [$];
  note_s       cur;

  exec_core i_exec_core (.sys_clk(sys_clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_op(instr_op), .rd_idx(rd_idx), .rr_idx(rr_idx), .imm_k(imm_k),
    .bit_sel(bit_sel), .br_offset(br_offset),
    .next_two_word(next_two_word), .io_value(io_value),
    .rf_load_en(rf_load_en), .rf_load_idx(rf_load_idx),
    .rf_load_data(rf_load_data), .status_register_load_en(status_register_load_en),
    .status_register_load_data(status_register_load_data), .rf_peek_idx(rf_peek_idx),
    .rf_peek_data(rf_peek_data), .pc_out(pc_out), .status_register_out(status_register_out),
    .stack_push(stack_push), .stack_data(stack_data));

  always #12.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Fills every register and the low six status bits with fresh random values; status bits 7 and 6 load as zero.
  task automatic preload();
    for (int i = 0; i < 32; i++) begin
      @(negedge sys_clk);
      rf_load_en = 1'b1;
      rf_load_idx = 5'(i);
      rf_load_data = seed[7:0];
      rf[i] = seed[7:0];
      seed = lfsr(seed);
    end
    @(negedge sys_clk);
    rf_load_en = 1'b0;
    status_register_load_en = 1'b1;
    status_register_load_data = seed[7:0] & 8'h3f;
    sr = seed[7:0] & 8'h3f;
    @(negedge sys_clk);
    status_register_load_en = 1'b0;
  endtask

  // Models the instruction, queues the note, then presents it until taken.
  task automatic send(op_e op, logic [4:0] d, logic [4:0] r, logic [7:0] k,
                      logic [2:0] b, logic [6:0] o, logic tw, logic [7:0] io,
                      bit gap);
    note_s       nt;
    logic [8:0]  s;
    logic [4:0]  h;
    logic [7:0]  a, y, res;
    logic [15:0] w, rw, npc;
    logic        cin, sub, hit;
    int          mode, n;
    a = rf[d];
    y = rf[r];
    cin = 1'b0;
    sub = op inside {OP_SUB, OP_IMM_DIFF, OP_DIFF_BRW, OP_IMM_DIFF_BRW,
                     OP_REG_CMP, OP_CMP_BRW, OP_IMM_CMP};
    mode = (sub || op inside {OP_ADD, OP_ADD_CARRY}) ? 1 : 0;
    if (op inside {OP_AND, OP_MASK_IMM, OP_OR, OP_MERGE_IMM, OP_EXCL_MERGE,
                   OP_SET_MASK, OP_ZERO_MINUS}) mode = 2;
    if (op inside {OP_IMM_DIFF, OP_IMM_DIFF_BRW, OP_IMM_CMP}) y = k;
    if (op inside {OP_ADD_CARRY, OP_DIFF_BRW, OP_IMM_DIFF_BRW, OP_CMP_BRW})
      cin = sr[SR_C];
    hit = 1'b0;
    res = a;
    npc = pc + 16'h0001;
    nt = '{default: '0};
    nt.cyc = 1;
    case (op)
      OP_AND:                    res = a & y;
      OP_MASK_IMM:               res = a & k;
      OP_OR:                     res = a | y;
      OP_MERGE_IMM, OP_SET_MASK: res = a | k;
      OP_EXCL_MERGE:             res = a ^ y;
      OP_WORD_SUM, OP_WORD_DIFF: begin
        w = {rf[{d[4:1], 1'b1}], rf[{d[4:1], 1'b0}]};
        rw = (op == OP_WORD_SUM) ? w + {10'h000, k[5:0]}
                                 : w - {10'h000, k[5:0]};
        sr[SR_V] = (op == OP_WORD_SUM) ? ~w[15] & rw[15] : w[15] & ~rw[15];
        sr[SR_C] = (op == OP_WORD_SUM) ? ~rw[15] & w[15] : rw[15] & ~w[15];
        sr[SR_Z] = (rw == 16'h0000);
        sr[SR_N] = rw[15];
        sr[SR_S] = rw[15] ^ sr[SR_V];
        {rf[{d[4:1], 1'b1}], rf[{d[4:1], 1'b0}]} = rw;
        nt.cyc = 2;
      end
      OP_PTR_JUMP, OP_PTR_CALL: begin
        npc = {rf[31], rf[30]};
        nt.call = (op == OP_PTR_CALL);
        nt.cyc = nt.call ? 3 : 2;
        nt.stk = pc + 16'h0001;
      end
      OP_EQUAL_SKIP:  hit = (a == y);
      OP_SKIP_REG_LO: hit = !y[b];
      OP_SKIP_REG_HI: hit = y[b];
      OP_SKIP_IO_LO:  hit = !io[b];
      OP_SKIP_IO_HI:  hit = io[b];
      OP_BR_STAT_HI:  hit = sr[b];
      OP_BR_STAT_LO:  hit = !sr[b];
      OP_BR_NO_CARRY: hit = !sr[SR_C];
      default: ;
    endcase
    if (mode == 1) begin
      s = sub ? {1'b0, a} - {1'b0, y} - 9'(cin)
              : {1'b0, a} + {1'b0, y} + 9'(cin);
      h = sub ? {1'b0, a[3:0]} - {1'b0, y[3:0]} - 5'(cin)
              : {1'b0, a[3:0]} + {1'b0, y[3:0]} + 5'(cin);
      res = s[7:0];
      sr[SR_C] = s[8];
      sr[SR_H] = h[4];
      sr[SR_V] = sub ? (a[7] & ~y[7] & ~res[7]) | (~a[7] & y[7] & res[7])
                     : (a[7] & y[7] & ~res[7]) | (~a[7] & ~y[7] & res[7]);
    end
    if (mode == 2) sr[SR_V] = 1'b0;
    if (mode != 0) begin
      sr[SR_Z] = (res == 8'h00);
      sr[SR_N] = res[7];
      if (!(op inside {OP_REG_CMP, OP_CMP_BRW, OP_IMM_CMP})) rf[d] = res;
    end
    if (hit && op >= OP_BR_STAT_HI) begin
      npc = pc + {{9{o[6]}}, o} + 16'h0001;
      nt.cyc = 2;
    end else if (hit) begin
      npc = pc + (tw ? 16'h0003 : 16'h0002);
      nt.cyc = tw ? 3 : 2;
    end
    pc = npc;
    nt.pc = npc;
    nt.sr = sr;
    nt.rv = rf[d];
    notes.push_back(nt);
    @(negedge sys_clk);
    instr_valid = 1'b1;
    instr_op = op;
    rd_idx = d;
    rr_idx = r;
    imm_k = k;
    bit_sel = b;
    br_offset = o;
    next_two_word = tw;
    io_value = io;
    rf_peek_idx = d;
    n = 0;
    while (instr_ready !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    if (gap) begin
      @(negedge sys_clk);
      instr_valid = 1'b0;
      while (instr_ready !== 1'b1 && n < 16) begin
        @(negedge sys_clk);
        n++;
      end
    end
  endtask

  // Peek data lags by a cycle, so the register check trails the rest.
  always @(posedge sys_clk) begin
    if (pk_pend) begin
      `CHK(rf_peek_data, pk_val)
      pk_pend = 1'b0;
    end
    if (active) begin
      if (stack_push === 1'b1) pushes++;
      if (instr_ready === 1'b1) begin
        active = 1'b0;
        cur = notes.pop_front();
        `CHK(cnt, cur.cyc)
        `CHK(pc_out, cur.pc)
        `CHK(status_register_out, cur.sr)
        `CHK(pushes, cur.call ? 1 : 0)
        if (cur.call) `CHK(stack_data, cur.stk)
        pk_val = cur.rv;
        pk_pend = 1'b1;
      end else begin
        cnt++;
      end
    end
    if (rst_n === 1'b1 && instr_valid === 1'b1 && instr_ready === 1'b1) begin
      active = 1'b1;
      cnt = 1;
      pushes = 0;
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    foreach (rf[i]) rf[i] = 8'h00;
    sr = 8'h00;
    pc = 16'h0000;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    preload();
    for (int i = 0; i < 28; i++) begin
      send(op_e'(i), seed[4:0], seed[9:5], seed[17:10], seed[20:18],
           seed[27:21], seed[28], seed[31:24], 1'b1);
      seed = lfsr(lfsr(seed));
    end
    // Back-to-back and held requests share one destination for the peek.
    send(OP_ADD, 5'h01, 5'h02, 8'h00, 3'h0, 7'h00, 1'b0, 8'h00, 1'b0);
    send(OP_ADD_CARRY, 5'h01, 5'h03, 8'h00, 3'h0, 7'h00, 1'b0, 8'h00, 1'b0);
    send(OP_PTR_CALL, 5'h01, 5'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'h00, 1'b0);
    send(OP_SKIP_IO_HI, 5'h01, 5'h00, 8'h00, 3'h7, 7'h00, 1'b1, 8'h80, 1'b0);
    send(OP_SUB, 5'h01, 5'h04, 8'h00, 3'h0, 7'h00, 1'b0, 8'h00, 1'b1);
    for (int j = 0; j < 4; j++) begin
      preload();
      for (int i = 0; i < 80; i++) begin
        send(op_e'(5'(seed % 28)), seed[4:0], seed[9:5], seed[17:10],
             seed[20:18], seed[27:21], seed[28], seed[31:24], 1'b1);
        seed = lfsr(lfsr(seed));
      end
    end
    repeat (4) @(posedge sys_clk);
    give_verdict();
  end
endmodule // test_alu_branch_instruction_exec
